/* rtl/usmc_defs.vh */
// constants for the synchronous master clock serial unit
`ifndef USMC_DEFS_VH
`define USMC_DEFS_VH
`define USMC_DIV_W 16
`define USMC_DIV_DEFAULT 16'h0010
`define USMC_DATA_W 9
`define USMC_BITS_8 4'h8
`define USMC_BITS_9 4'h9
`define USMC_CNT_W 4
`endif

/* rtl/usmc_sync_master.v */
// synchronous master mode transmitter and receiver with emitted bit clock
`timescale 1ns/1ns
`include "usmc_defs.vh"
module usmc_sync_master (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_clock_output_enable,
  input wire i_transmitter_enable,
  input wire i_receiver_enable,
  input wire i_last_bit_clock_pulse,
  input wire i_serial_clock_polarity,
  input wire i_serial_clock_phase,
  input wire i_word_length_select,
  input wire i_send_break,
  input wire [`USMC_DIV_W-1:0] i_baud_div,
  input wire [`USMC_DATA_W-1:0] i_tx_data,
  input wire i_tx_valid,
  output wire o_tx_ready,
  output reg [`USMC_DATA_W-1:0] o_rx_data,
  output reg o_rx_valid,
  output reg o_busy,
  output reg o_serial_clock_out,
  output reg o_tx_line,
  input wire i_rx_line
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_START = 4'h2;
  localparam [3:0] ST_DATA = 4'h4;
  localparam [3:0] ST_STOP = 4'h8;
  reg [3:0] state_q;
  reg [`USMC_DIV_W-1:0] div_q;
  reg half_q;
  reg [`USMC_CNT_W-1:0] bit_q;
  reg [`USMC_DATA_W-1:0] sh_q;
  reg [`USMC_DATA_W-1:0] rx_q;
  reg brk_q;
  reg rx_s1_q;
  reg rx_s2_q;
  wire [`USMC_CNT_W-1:0] nbits;
  wire tick;
  wire last_bit;
  wire clk_gate;
  wire [`USMC_DIV_W-1:0] half_div;
  //////////////////////////////////////////////////////////////////////////////
  // frame timeline, in half bit ticks of the divider:
  //   idle   : line high, clock parked at its idle level
  //   take   : word latched, line driven low for the start bit
  //   start  : two ticks, clock held idle so the peer sees no edge
  //   data   : two ticks per bit, half_q low in the first half and high in
  //            the second; the line moves only at the end of a bit
  //   stop   : two ticks, line high, clock held idle
  //   return : received word published, busy dropped in the same cycle
  // busy falls together with the return to idle, so ready can never be
  // seen while busy is still high; a new word is taken one cycle later.
  //
  // the clock is a registered copy of the gate and half_q, one system
  // cycle behind the sequencer. that costs a cycle of skew against the
  // line but keeps the pin free of the one cycle spikes that a
  // combinational mix of the divider tick would produce.
  //
  // limitation: the receiver captures through a two stage synchroniser,
  // so the divider must leave at least four system cycles per half bit
  // for a peer that answers on the emitted clock.
  //
  // limitation: the last data bit is still captured when its clock pulse
  // is suppressed; software should ignore that bit in such frames.
  //
  // polarity, phase and last pulse bits are read live; they must only be
  // changed while busy is low, otherwise a frame in flight
  // may show a short clock phase.
  //////////////////////////////////////////////////////////////////////////////
  // frame length and baud tick; a half bit tick gives the two clock edges
  assign nbits = i_word_length_select ? `USMC_BITS_9 : `USMC_BITS_8;
  assign half_div = {1'b0, i_baud_div[`USMC_DIV_W-1:1]};
  assign tick = (div_q == 16'h0000);
  assign last_bit = (bit_q == nbits - 4'h1);
  // accept a word only in sync mode with transmitter on
  assign o_tx_ready = (state_q == ST_IDLE) & i_transmitter_enable & i_clock_output_enable
                      & ~i_send_break;
  // clock pulses only in data bits, optionally not in the last one
  assign clk_gate = (state_q == ST_DATA) & ~brk_q & (~last_bit | i_last_bit_clock_pulse);
  //////////////////////////////////////////////////////////////////////////////
  // rx line is an outside pin: two stage synchroniser before use
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= i_rx_line;
      rx_s2_q <= rx_s1_q;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // frame sequencer: start, data lsb first, stop, as in async framing
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      div_q <= 16'h0000;
      half_q <= 1'b0;
      bit_q <= 4'h0;
      sh_q <= 9'h000;
      rx_q <= 9'h000;
      o_rx_data <= 9'h000;
      o_rx_valid <= 1'b0;
      o_busy <= 1'b0;
      o_tx_line <= 1'b1;
    end else begin
      o_rx_valid <= 1'b0;
      div_q <= tick ? half_div : div_q - 16'h0001;
      case (state_q)
        ST_IDLE: begin
          half_q <= 1'b0;
          bit_q <= 4'h0;
          o_busy <= 1'b0;
          o_tx_line <= ~(i_send_break & i_transmitter_enable);
          if (i_tx_valid & o_tx_ready) begin
            sh_q <= i_tx_data;
            o_busy <= 1'b1;
            o_tx_line <= 1'b0;
            div_q <= half_div;
            state_q <= ST_START;
          end
        end
        ST_START: begin
          if (tick) begin
            half_q <= ~half_q;
            if (half_q) begin
              o_tx_line <= sh_q[0];
              state_q <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (tick) begin
            half_q <= ~half_q;
            // in phase 0 the first half edge is the leading edge and the second the trailing edge; phase 1 swaps them
            if (~half_q) begin
              // phase 0 captures on the first edge
              if (~i_serial_clock_phase & i_receiver_enable) begin
                rx_q[bit_q] <= rx_s2_q;
              end
            end else begin
              if (i_serial_clock_phase & i_receiver_enable) begin
                rx_q[bit_q] <= rx_s2_q;
              end
              if (last_bit) begin
                o_tx_line <= 1'b1;
                state_q <= ST_STOP;
              end else begin
                o_tx_line <= sh_q[bit_q + 4'h1];
                bit_q <= bit_q + 4'h1;
              end
            end
          end
        end
        ST_STOP: begin
          if (tick) begin
            half_q <= ~half_q;
            if (half_q) begin
              o_rx_data <= rx_q;
              o_rx_valid <= i_receiver_enable;
              o_busy <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // break request register; it only gates the clock, the line itself is
  // driven low from idle by the sequencer, so a break mid frame leaves the line alone but stops the clock
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      brk_q <= 1'b0;
    end else begin
      brk_q <= i_send_break & i_transmitter_enable;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // emitted clock: idle level is the polarity bit; half_q marks the second
  // half of a data bit, so phase 0 puts the first edge mid bit and phase 1
  // at the start of the bit; two edges per clocked bit
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_serial_clock_out <= 1'b0;
    end else if (clk_gate & i_clock_output_enable) begin
      o_serial_clock_out <= i_serial_clock_polarity ^ half_q
                            ^ i_serial_clock_phase;
    end else begin
      o_serial_clock_out <= i_serial_clock_polarity;
    end
  end
endmodule

/* tb/usmc_props.sv */
// concurrent checks for the synchronous master serial unit
`timescale 1ns/1ns
module usmc_props (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_clock_output_enable,
  input wire i_last_bit_clock_pulse,
  input wire i_serial_clock_polarity,
  input wire i_word_length_select,
  input wire i_send_break,
  input wire i_tx_valid,
  input wire o_tx_ready,
  input wire o_rx_valid,
  input wire o_busy,
  input wire o_serial_clock_out,
  input wire o_tx_line
);
  default clocking dc @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  reg ck_q;
  reg [5:0] tg_q;
  // clock toggles per frame; a stray start or stop pulse shows up here
  always @(posedge i_clock) begin
    ck_q <= o_serial_clock_out;
    tg_q <= (i_sys_rst || !o_busy) ? 6'h00 : tg_q + {5'h00, ck_q ^ o_serial_clock_out};
  end
  a_sync_gate: assert property (!i_clock_output_enable |-> !o_tx_ready)
    else $error("ready with sync off");
  a_busy_refuse: assert property (o_busy |-> !o_tx_ready) else $error("ready busy");
  a_idle_level: assert property ((!o_busy && $stable(i_serial_clock_polarity)) [*2]
    |-> o_serial_clock_out == i_serial_clock_polarity) else $error("idle level");
  a_start_low: assert property (i_tx_valid && o_tx_ready |=> !o_tx_line && o_busy)
    else $error("no start bit");
  a_start_quiet: assert property (i_tx_valid && o_tx_ready
    |=> $stable(o_serial_clock_out) [*4]) else $error("start clocked");
  a_break_low: assert property (i_send_break && $past(i_send_break) && !o_busy
    |-> !o_tx_line) else $error("break high");
  a_rx_pulse: assert property (o_rx_valid |=> !o_rx_valid) else $error("rx pulse");
  a_clk_count: assert property ($fell(o_busy) |-> tg_q ==
    (i_word_length_select ? 6'h12 : 6'h10) - (i_last_bit_clock_pulse ? 6'h00 : 6'h02))
    else $error("clock count");
endmodule
bind usmc_sync_master usmc_props chk_u (.*);

/* tb/usmc_peer.sv */
// far side peripheral: loops data back so rx is predictable from tx
`timescale 1ns/1ns
module usmc_peer (
  input wire i_tx_line,
  output wire o_rx_line
);
  assign o_rx_line = i_tx_line;
endmodule

/* tb/tb.sv */
// self-checking bench for the synchronous master serial unit
`timescale 1ns/1ns
module tb;
  reg i_clock = 1'h0, i_sys_rst = 1'h1, i_clock_output_enable = 1'h1;
  reg i_transmitter_enable = 1'h0, i_receiver_enable = 1'h0, i_last_bit_clock_pulse = 1'h0;
  reg i_serial_clock_polarity = 1'h0, i_serial_clock_phase = 1'h0, i_word_length_select = 1'h0;
  reg i_send_break = 1'h0, i_tx_valid = 1'h0;
  reg [8:0] i_tx_data = 9'h000, m;
  reg [12:0] rows [0:4];
  wire [15:0] i_baud_div = 16'h0004;
  wire o_tx_ready, o_rx_valid, o_busy, o_serial_clock_out, o_tx_line, i_rx_line;
  wire [8:0] o_rx_data;
  integer error_cnt = 0, samples_checked = 0, i;
  usmc_sync_master dut_u (.*);
  usmc_peer peer_u (.i_tx_line(o_tx_line), .o_rx_line(i_rx_line));
  task chk(input string nm, input [8:0] e, input [8:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task end_of_test;
    $display("mismatches %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial forever #5 i_clock = ~i_clock;
  // a hung handshake ends here rather than running forever
  initial begin
    #100000 error_cnt = error_cnt + 1;
    end_of_test;
  end
  // rows: word length, last pulse, polarity, phase, data; inputs move on falling edges
  initial begin
    rows = '{13'h08A5, 13'h0E3C, 13'h19C3, 13'h155A, 13'h02FF};
    #20 i_sys_rst = 1'h0;
    for (i = 0; i < 5; i = i + 1) begin
      while (o_busy !== 1'h0) #10;
      {i_transmitter_enable, i_receiver_enable} = 2'h0;
      #10 {i_word_length_select, i_last_bit_clock_pulse, i_serial_clock_polarity,
        i_serial_clock_phase, i_tx_data} = rows[i];
      #10 {i_transmitter_enable, i_receiver_enable, i_tx_valid} = 3'h7;
      while (o_tx_ready !== 1'h1) #10;
      #10 i_tx_valid = 1'h0;
      while (o_rx_valid !== 1'h1) #10;
      m = (i_word_length_select ? 9'h1FF : 9'h0FF) >> !i_last_bit_clock_pulse;
      chk("rx_data", i_tx_data & m, o_rx_data & m);
    end
    while (o_busy !== 1'h0) #10;
    i_send_break = 1'h1;
    #30 chk("break", 9'h000, {o_tx_line, o_tx_ready, 7'h00});
    i_send_break = 1'h0;
    i_clock_output_enable = 1'h0;
    #10 chk("sync off", 9'h000, {8'h00, o_tx_ready});
    // mid-run reset: line high, idle, no pulse, clock low
    i_sys_rst = 1'h1;
    #20 chk("reset", 9'h100, {o_tx_line, o_busy, o_rx_valid, o_serial_clock_out, 5'h00});
    i_sys_rst = 1'h0;
    #20 end_of_test;
  end
endmodule
